/* verilog/nvram_host.sv */
// How it works
// - address set with the write strobe, held until write ends
// - output drive kept high through writes
// - write strobe falls with both selects entering store
// - recall state held initiation minimum, then released
// - no access until power-up recall elapsed after reset or a low supply seen in idle
// - controls idle, never write, during power-up after reset or a low supply seen in idle
`timescale 1ns/1ps
`default_nettype none

module nvram_host #(
  parameter int unsigned STORE_WAIT = nvram_host_pkg::STORE_CYC,
  parameter int unsigned RECALL_WAIT = nvram_host_pkg::RECALL_CYC,
  parameter int unsigned RESTORE_WAIT = nvram_host_pkg::RESTORE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire nvram_host_pkg::req_t req,
  // user answer
  output logic rsp_valid,
  output logic [nvram_host_pkg::DATA_W-1:0] rsp_data,
  output logic store_refused,
  // supply monitor, high when above the trigger level
  input wire logic supply_ok,
  // memory pins
  output nvram_host_pkg::ctl_t ctl,
  output logic [nvram_host_pkg::ADDR_W-1:0] byte_index,
  output logic [nvram_host_pkg::DATA_W-1:0] shared_data_lines_out,
  output logic shared_data_lines_oe,
  input wire logic [nvram_host_pkg::DATA_W-1:0] shared_data_lines_in
);

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_ACTIVE,
    ST_RELEASE,
    ST_WAIT,
    ST_DONE
  } state_t;

  localparam int unsigned CW = nvram_host_pkg::CNT_W;

  state_t state, next_state;
  logic [CW-1:0] count, next_count;
  nvram_host_pkg::req_t cur, next_cur;
  nvram_host_pkg::ctl_t next_ctl;
  logic [nvram_host_pkg::ADDR_W-1:0] next_byte_index;
  logic [nvram_host_pkg::DATA_W-1:0] next_data_out;
  logic next_oe;
  logic next_rsp_valid;
  logic [nvram_host_pkg::DATA_W-1:0] next_rsp_data;
  logic next_refused;
  logic [nvram_host_pkg::DATA_W-1:0] data_sync;
  logic [0:0] supply_sync;

  pin_sync #(.WIDTH(nvram_host_pkg::DATA_W)) u_data_sync (
    .clk(clk),
    .srst(srst),
    .async_in(shared_data_lines_in),
    .sync_out(data_sync)
  );

  pin_sync #(.WIDTH(1)) u_supply_sync (
    .clk(clk),
    .srst(srst),
    .async_in(supply_ok),
    .sync_out(supply_sync)
  );

  // control pins for the active phase of each operation
  function automatic nvram_host_pkg::ctl_t active_ctl(input nvram_host_pkg::op_t op);
    nvram_host_pkg::ctl_t c;
    c = nvram_host_pkg::CTL_IDLE;
    unique case (op)
      nvram_host_pkg::OP_READ:
      begin
        c.chip_sel_n = 1'b0;
        c.out_en_n = 1'b0;
      end
      nvram_host_pkg::OP_WRITE:
      begin
        c.chip_sel_n = 1'b0;
        c.write_n = 1'b0;
      end
      nvram_host_pkg::OP_STORE:
      begin
        c.nv_select_n = 1'b0;
        c.chip_sel_n = 1'b0;
        c.write_n = 1'b0;
      end
      nvram_host_pkg::OP_RECALL:
      begin
        c.nv_select_n = 1'b0;
        c.chip_sel_n = 1'b0;
        c.out_en_n = 1'b0;
      end
      default:
      begin
        c = nvram_host_pkg::CTL_IDLE;
      end
    endcase
    return c;
  endfunction : active_ctl

  // cycles the active phase is held
  function automatic logic [CW-1:0] hold_cycles(input nvram_host_pkg::op_t op);
    unique case (op)
      nvram_host_pkg::OP_READ:
        return CW'(nvram_host_pkg::ACCESS_CYC + nvram_host_pkg::SYNC_CYC);
      nvram_host_pkg::OP_WRITE: return CW'(nvram_host_pkg::WRITE_CYC);
      default: return CW'(nvram_host_pkg::INIT_CYC);
    endcase
  endfunction : hold_cycles

  assign req_ready = (state == ST_IDLE);

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_cur = cur;
    next_ctl = ctl;
    next_byte_index = byte_index;
    next_data_out = shared_data_lines_out;
    next_oe = shared_data_lines_oe;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_refused = 1'b0;
    unique case (state)
      ST_POWERUP:
      begin
        next_ctl = nvram_host_pkg::CTL_IDLE;
        if (!supply_sync[0])
        begin
          next_count = '0;
        end
        else if (count >= CW'(RESTORE_WAIT))
        begin
          next_state = ST_IDLE;
        end
        else
        begin
          next_count = count + CW'(1);
        end
      end
      ST_IDLE:
      begin
        if (!supply_sync[0])
        begin
          next_state = ST_POWERUP;
          next_count = '0;
        end
        else if (req_valid)
        begin
          if (req.op == nvram_host_pkg::OP_STORE && !supply_sync[0])
          begin
            next_refused = 1'b1;
          end
          else
          begin
            next_cur = req;
            next_byte_index = req.addr;
            next_data_out = req.data;
            next_oe = (req.op == nvram_host_pkg::OP_WRITE);
            next_ctl = active_ctl(req.op);
            next_count = hold_cycles(req.op);
            next_state = ST_ACTIVE;
          end
        end
      end
      ST_ACTIVE:
      begin
        if (count > CW'(1))
        begin
          next_count = count - CW'(1);
        end
        else
        begin
          if (cur.op == nvram_host_pkg::OP_STORE && !supply_sync[0])
          begin
            next_refused = 1'b1;
          end
          if (cur.op == nvram_host_pkg::OP_READ)
          begin
            next_rsp_data = data_sync;
          end
          // end every cycle by raising all controls
          next_ctl = nvram_host_pkg::CTL_IDLE;
          next_count = CW'(nvram_host_pkg::TURN_CYC);
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        next_oe = 1'b0;
        if (count > CW'(1))
        begin
          next_count = count - CW'(1);
        end
        else if (cur.op == nvram_host_pkg::OP_STORE)
        begin
          next_count = CW'(STORE_WAIT);
          next_state = ST_WAIT;
        end
        else if (cur.op == nvram_host_pkg::OP_RECALL)
        begin
          next_count = CW'(RECALL_WAIT);
          next_state = ST_WAIT;
        end
        else
        begin
          next_state = ST_DONE;
        end
      end
      ST_WAIT:
      begin
        // pins stay idle while the device works alone
        if (count > CW'(1))
        begin
          next_count = count - CW'(1);
        end
        else
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (srst)
    begin
      next_state = ST_POWERUP;
      next_count = '0;
      next_cur = '0;
      next_ctl = nvram_host_pkg::CTL_IDLE;
      next_byte_index = '0;
      next_data_out = '0;
      next_oe = 1'b0;
      next_rsp_valid = 1'b0;
      next_rsp_data = '0;
      next_refused = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    state <= next_state;
    count <= next_count;
    cur <= next_cur;
    ctl <= next_ctl;
    byte_index <= next_byte_index;
    shared_data_lines_out <= next_data_out;
    shared_data_lines_oe <= next_oe;
    rsp_valid <= next_rsp_valid;
    rsp_data <= next_rsp_data;
    store_refused <= next_refused;
  end

endmodule : nvram_host

`default_nettype wire

/* verilog/nvram_host_pkg.sv */
package nvram_host_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DEPTH = 512;

  // clock rate in kHz and pin timing in ns
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CLK_NS = 8;
  localparam int unsigned ACCESS_NS = 45;
  localparam int unsigned WRITE_PULSE_NS = 30;
  localparam int unsigned INIT_NS = 20;
  localparam int unsigned TURN_NS = 15;
  localparam int unsigned STORE_US = 10000;
  localparam int unsigned RECALL_US = 20;
  localparam int unsigned RESTORE_US = 550;
  // cycles the data pins spend in the two-stage synchroniser
  localparam int unsigned SYNC_CYC = 2;

  // least times round up
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TURN_CYC = (TURN_NS + CLK_NS - 1) / CLK_NS;
  // waits for the device to finish also round up, so the host never comes early
  localparam int unsigned STORE_CYC = (STORE_US * (CLK_KHZ / 1000)) + 1;
  localparam int unsigned RECALL_CYC = (RECALL_US * (CLK_KHZ / 1000)) + 1;
  localparam int unsigned RESTORE_CYC = (RESTORE_US * (CLK_KHZ / 1000)) + 1;

  localparam int unsigned CNT_W = 21;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_STORE,
    OP_RECALL
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  // active-low pin group toward the memory
  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_en_n;
    logic nv_select_n;
  } ctl_t;

  localparam ctl_t CTL_IDLE = '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
    nv_select_n: 1'b1};

endpackage : nvram_host_pkg

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for the shared data inputs and the supply flag
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb
  begin
    next_stage1 = srst ? '0 : async_in;
    next_sync_out = srst ? '0 : stage1;
  end

  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule : pin_sync

`default_nettype wire

/* testbench/nvram_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module nvram_host_checker (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watched ports
  input wire logic req_ready,
  input wire logic supply_ok,
  input wire nvram_host_pkg::ctl_t ctl,
  input wire logic [8:0] byte_index,
  input wire logic shared_data_lines_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_ADDR_HOLD:
    assert property (!ctl.chip_sel_n && !ctl.write_n && $past(!ctl.chip_sel_n && !ctl.write_n)
      |-> $stable(byte_index)) else $error("address moved in write");
  AST_OUT_OFF_IN_WRITE:
    assert property (!ctl.write_n |-> ctl.out_en_n) else $error("output drive low in write");
  AST_NO_FIGHT:
    assert property (shared_data_lines_oe |-> ctl.out_en_n && ctl.nv_select_n)
      else $error("host drives data while memory may");
  AST_RECALL_WE_HIGH:
    assert property (!ctl.nv_select_n && !ctl.out_en_n |-> ctl.write_n)
      else $error("write strobe low in recall");
  AST_NV_INIT:
    assert property ($fell(ctl.nv_select_n) |-> (!ctl.nv_select_n) [*3])
      else $error("nv initiation too short");
  AST_STORE_LAST:
    assert property ($fell(ctl.nv_select_n) && !ctl.write_n
      |-> $fell(ctl.write_n) || $fell(ctl.chip_sel_n)) else $error("store entry order");
  AST_WR_PULSE:
    assert property ($fell(ctl.write_n) && ctl.nv_select_n |-> (!ctl.write_n) [*4])
      else $error("write pulse too short");
  AST_READY_IDLE:
    assert property (req_ready |-> ctl == nvram_host_pkg::CTL_IDLE)
      else $error("ready while controls active");
  AST_LOW_SUPPLY:
    assert property ((!supply_ok) [*5] |-> !req_ready) else $error("ready at low supply");
endmodule : nvram_host_checker
bind nvram_host nvram_host_checker u_chk (.clk(clk), .srst(srst), .req_ready(req_ready),
  .supply_ok(supply_ok), .ctl(ctl), .byte_index(byte_index),
  .shared_data_lines_oe(shared_data_lines_oe));
`default_nettype wire

/* testbench/nvram_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nvram_dev_model #(
  parameter int STORE_T = 100,
  parameter int RECALL_T = 80,
  parameter int RESTORE_T = 100
) (
  // pins
  input wire nvram_host_pkg::ctl_t ctl,
  input wire logic [8:0] byte_index,
  input wire logic [7:0] host_d,
  input wire logic host_oe,
  input wire logic vcc_ok,
  output logic [7:0] dq
);
  logic [7:0] sram [512];
  logic [7:0] nv [512];
  logic [7:0] last;
  logic busy;
  wire sel = !ctl.chip_sel_n && ctl.nv_select_n;
  wire rd = sel && ctl.write_n && !ctl.out_en_n;
  wire wr = sel && !ctl.write_n;
  wire st = !ctl.chip_sel_n && !ctl.write_n && ctl.out_en_n && !ctl.nv_select_n;
  wire rc = !ctl.chip_sel_n && ctl.write_n && !ctl.out_en_n && !ctl.nv_select_n;
  initial
  begin
    busy = 1'b0;
    last = 8'h00;
    foreach (nv[i]) nv[i] = i[7:0] ^ 8'h5a;
    foreach (sram[i]) sram[i] = 8'h00;
  end
  task automatic do_recall(input int t);
    busy = 1'b1;
    foreach (sram[i]) sram[i] = 8'h00;
    #t;
    sram = nv;
    busy = 1'b0;
  endtask : do_recall
  always @(negedge wr)
    if (!busy) sram[byte_index] = host_d;
  // edge triggered, so a held state never starts a second cycle
  always @(posedge st)
    if (!busy && vcc_ok)
    begin
      busy = 1'b1;
      foreach (nv[i]) nv[i] = 8'hff;
      #STORE_T;
      nv = sram;
      busy = 1'b0;
    end
  always @(posedge rc)
    if (!busy) do_recall(RECALL_T);
  always @(posedge vcc_ok)
    do_recall(RESTORE_T);
  always @(rd or byte_index or busy)
    if (rd && !busy) last = sram[byte_index];
  // released lines show the inverse of the last byte
  assign dq = host_oe ? host_d : ((rd && !busy) ? sram[byte_index] : ~last);
endmodule : nvram_dev_model
`default_nettype wire

/* testbench/nvram_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nvram_host_tb;
  logic clk;
  logic srst;
  logic req_valid;
  logic req_ready;
  nvram_host_pkg::req_t req;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic store_refused;
  logic supply_ok;
  nvram_host_pkg::ctl_t ctl;
  logic [8:0] byte_index;
  logic [7:0] d_out;
  logic d_oe;
  logic [7:0] d_in;
  int n_mismatch;
  int n_compared;
  int cyc;
  int n_refused;
  nvram_host #(.STORE_WAIT(20), .RECALL_WAIT(20), .RESTORE_WAIT(20)) DUT (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .store_refused(store_refused),
    .supply_ok(supply_ok), .ctl(ctl), .byte_index(byte_index), .shared_data_lines_out(d_out),
    .shared_data_lines_oe(d_oe), .shared_data_lines_in(d_in));
  nvram_dev_model mem (.ctl(ctl), .byte_index(byte_index), .host_d(d_out), .host_oe(d_oe),
    .vcc_ok(supply_ok), .dq(d_in));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cyc++;
    if (store_refused === 1'b1)
      n_refused++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic op(input nvram_host_pkg::op_t o, input logic [8:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000)
      n_mismatch++;
    req_valid = 1'b1;
    req = '{op: o, addr: a, data: d};
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 5000)
      n_mismatch++;
  endtask : op
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    op(nvram_host_pkg::OP_READ, a, 8'h00);
    chk(rsp_data, e);
  endtask : rd_chk
  task test_powerup;
    rd_chk(9'h005, 8'h5f);
    rd_chk(9'h1ff, 8'ha5);
    $display("test_powerup done");
  endtask : test_powerup
  task test_wr_rd;
    logic [8:0] a [4];
    a = '{9'h000, 9'h001, 9'h100, 9'h1ff};
    foreach (a[i]) op(nvram_host_pkg::OP_WRITE, a[i], a[i][7:0] + 8'h11);
    foreach (a[i]) rd_chk(a[i], a[i][7:0] + 8'h11);
    $display("test_wr_rd done");
  endtask : test_wr_rd
  task test_store_recall;
    op(nvram_host_pkg::OP_WRITE, 9'h009, 8'hc3);
    op(nvram_host_pkg::OP_STORE, 9'h000, 8'h00);
    rd_chk(9'h009, 8'hc3);
    op(nvram_host_pkg::OP_WRITE, 9'h009, 8'h3c);
    rd_chk(9'h009, 8'h3c);
    op(nvram_host_pkg::OP_RECALL, 9'h000, 8'h00);
    rd_chk(9'h009, 8'hc3);
    op(nvram_host_pkg::OP_RECALL, 9'h000, 8'h00);
    rd_chk(9'h1ff, 8'h10);
    $display("test_store_recall done");
  endtask : test_store_recall
  task test_brownout;
    op(nvram_host_pkg::OP_WRITE, 9'h009, 8'h00);
    // supply dips as a store is taken: both sides refuse it, the rise recalls
    req_valid = 1'b1;
    req = '{op: nvram_host_pkg::OP_STORE, addr: 9'h000, data: 8'h00};
    supply_ok = 1'b0;
    @(negedge clk);
    req_valid = 1'b0;
    @(negedge clk);
    supply_ok = 1'b1;
    repeat (40) @(negedge clk);
    chk(n_refused[7:0], 8'h01);
    rd_chk(9'h009, 8'hc3);
    op(nvram_host_pkg::OP_WRITE, 9'h009, 8'h00);
    supply_ok = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h00, req_ready}, 8'h00);
    supply_ok = 1'b1;
    rd_chk(9'h009, 8'hc3);
    $display("test_brownout done");
  endtask : test_brownout
  initial
  begin
    srst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    supply_ok = 1'b0;
    repeat (6) @(negedge clk);
    chk({4'h0, ctl}, {4'h0, nvram_host_pkg::CTL_IDLE});
    srst = 1'b0;
    supply_ok = 1'b1;
    test_powerup();
    test_wr_rd();
    test_store_recall();
    test_brownout();
    chk(n_refused[7:0], 8'h01);
    test_done();
  end
endmodule : nvram_host_tb
`default_nettype wire
